// [shared/keypad_gpio_pkg.sv]
// Shared constants, register map and types for the keypad and general purpose pin block
package keypad_gpio_pkg;

    localparam int NUM_ROWS = 8;
    localparam int NUM_COLS = 10;
    localparam int NUM_PINS = 18;
    localparam int NUM_KEYS = 80;

    // Register offsets
    localparam logic [7:0] OFS_PIN_STATE_ROWS    = 8'h14;
    localparam logic [7:0] OFS_PIN_STATE_COLS_LO = 8'h15;
    localparam logic [7:0] OFS_PIN_STATE_COLS_HI = 8'h16;
    localparam logic [7:0] OFS_IRQ_EN_ROWS       = 8'h1A;
    localparam logic [7:0] OFS_IRQ_EN_COLS_LO    = 8'h1B;
    localparam logic [7:0] OFS_IRQ_EN_COLS_HI    = 8'h1C;
    localparam logic [7:0] OFS_KP_SEL_ROWS       = 8'h1D;
    localparam logic [7:0] OFS_KP_SEL_COLS_LO    = 8'h1E;
    localparam logic [7:0] OFS_KP_SEL_COLS_HI    = 8'h1F;
    localparam logic [7:0] OFS_EVT_EN_ROWS       = 8'h20;
    localparam logic [7:0] OFS_EVT_EN_COLS_LO    = 8'h21;
    localparam logic [7:0] OFS_EVT_EN_COLS_HI    = 8'h23;
    localparam logic [7:0] OFS_DIR_ROWS          = 8'h23;
    localparam logic [7:0] OFS_DIR_COLS_LO       = 8'h24;
    localparam logic [7:0] OFS_DIR_COLS_HI       = 8'h25;
    localparam logic [7:0] OFS_POL_ROWS          = 8'h26;
    localparam logic [7:0] OFS_POL_COLS_LO       = 8'h27;
    localparam logic [7:0] OFS_POL_COLS_HI       = 8'h28;
    localparam logic [7:0] OFS_DBOFF_ROWS        = 8'h29;
    localparam logic [7:0] OFS_DBOFF_COLS_HI     = 8'h2B;
    localparam logic [7:0] OFS_DBOFF_COLS_LO     = 8'h30;

    // Reset value of every register and the mask of the two-pin groups
    localparam logic [7:0]          REG_RESET    = 8'h00;
    localparam logic [7:0]          HI_GROUP_MSK = 8'h03;
    localparam logic [NUM_PINS-1:0] PINS_RESET   = 18'h00000;

    // Timing
    localparam int CLK_MHZ             = 100;
    localparam int DEBOUNCE_US         = 50;
    localparam int DEBOUNCE_CYCLES     = DEBOUNCE_US * CLK_MHZ;
    localparam int SCAN_PERIOD_MS      = 25;
    localparam int SCAN_PERIOD_CYCLES  = SCAN_PERIOD_MS * 1000 * CLK_MHZ;
    localparam int SLOT_US             = 100;
    localparam int SLOT_CYCLES         = SLOT_US * CLK_MHZ;

    // Event encoding
    localparam int KEY_CODE_BASE   = 1;
    localparam int GPI_CODE_BASE   = 97;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_SLOT = 3'b010,
        ST_EMIT = 3'b100
    } scan_state_t;

    typedef struct packed {
        logic [NUM_PINS-1:0] sel;
        logic [NUM_PINS-1:0] evt;
        logic [NUM_PINS-1:0] dir;
        logic [NUM_PINS-1:0] pol;
        logic [NUM_PINS-1:0] dboff;
        logic [NUM_PINS-1:0] ien;
    } pin_cfg_t;

    typedef struct packed {
        logic       press;
        logic [6:0] code;
    } key_event_t;

endpackage

// [rtl/stable_filter.sv]
// Two-flop synchroniser and per-bit stability filter with per-bit bypass
`timescale 1ns/10ps
`default_nettype none
module stable_filter
#(
    parameter int             W             = 1,
    parameter int             STABLE_CYCLES = 5000,
    parameter logic [W-1:0]   LEVEL_RST     = '1
)
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] raw,
    input  wire logic [W-1:0] bypass,
    output logic      [W-1:0] level,
    output logic      [W-1:0] change
);
    localparam int CW = $clog2(STABLE_CYCLES + 1);

    typedef struct packed {
        logic [W-1:0]         s1;
        logic [W-1:0]         s2;
        logic [W-1:0]         lvl;
        logic [W-1:0]         chg;
        logic [W-1:0][CW-1:0] cnt;
    } filt_state_t;

    filt_state_t q;
    filt_state_t d;

    always_comb
    begin
        d     = q;
        d.s1  = raw;
        d.s2  = q.s1;
        for (int i = 0; i < W; i++)
        begin
            if (bypass[i])
            begin
                d.lvl[i] = q.s2[i];
                d.cnt[i] = '0;
            end
            else if (q.s2[i] == q.lvl[i])
            begin
                d.cnt[i] = '0;
            end
            else if (q.cnt[i] == CW'(STABLE_CYCLES - 1))
            begin
                d.lvl[i] = q.s2[i];
                d.cnt[i] = '0;
            end
            else
            begin
                d.cnt[i] = q.cnt[i] + CW'(1);
            end
        end
        d.chg = d.lvl ^ q.lvl;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q.s1  <= LEVEL_RST;
            q.s2  <= LEVEL_RST;
            q.lvl <= LEVEL_RST;
            q.chg <= '0;
            q.cnt <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign level  = q.lvl;
    assign change = q.chg;

endmodule // stable_filter
`default_nettype wire

// [rtl/keypad_gpio_pin_config.sv]
// Pin configuration, input conditioning and key matrix scanning for the keypad block
//
// How it works
// - Select bit zero: general pin, direction-driven
// - Select bit one: fixed row or column
// - Rows, columns 0-7, columns 8-9 byte mapping
// - Event bit zero: no input events queued
// - General input with event bit: queue presses and releases
// - Direction zero input, one drives output
// - Polarity zero: falling edge or low
// - Polarity one: rising edge or high
// - Debounce inputs while disable bit zero
// - Disable bit one bypasses debouncing
// - Same debounce setting for rows, inputs
// - Reset pin always debounced 50 us
// - New level accepted after 50 us stable
// - Columns scanned once per 25 ms
// - Two matching scans confirm a key
// - Detection latency 25 to 50 ms
// - Key codes 1-80, inputs 97-114, bit7 press
// - Enabled input edge matching polarity sets interrupt flag
// - Debounced pin state stays default until change
`timescale 1ns/10ps
`default_nettype none
module keypad_gpio_pin_config
    import keypad_gpio_pkg::*;
#(
    parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
    parameter int PERIOD_LEN   = SCAN_PERIOD_CYCLES,
    parameter int SLOT_LEN     = SLOT_CYCLES
)
(
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    input  wire logic [NUM_PINS-1:0] pin_in,
    output logic      [NUM_PINS-1:0] pin_out,
    output logic      [NUM_PINS-1:0] pin_oe,
    input  wire logic [NUM_PINS-1:0] gpo_data,
    input  wire logic                rst_pin_n,
    output logic                     reset_req,
    output logic                     event_valid,
    output logic      [7:0]          event_code,
    output logic                     general_input_irq_flag,
    input  wire logic                irq_flag_clear
);
    localparam int PW = $clog2(PERIOD_LEN);
    localparam int SW = $clog2(SLOT_LEN);

    typedef struct packed {
        pin_cfg_t            cfg;
        logic [NUM_PINS-1:0] sel_snap;
        logic [NUM_PINS-1:0] dboff_snap;
        scan_state_t         state;
        logic [PW-1:0]       period_cnt;
        logic [SW-1:0]       slot_cnt;
        logic [3:0]          col;
        logic [6:0]          key_idx;
        logic [NUM_KEYS-1:0] cur_img;
        logic [NUM_KEYS-1:0] prev_img;
        logic [NUM_KEYS-1:0] rep_img;
        logic [NUM_PINS-1:0] gpi_pend;
        logic [NUM_PINS-1:0] gpi_press;
        logic [NUM_PINS-1:0] pin_state;
        logic                irq_flag;
        logic                ev_valid;
        key_event_t          ev;
        logic [NUM_PINS-1:0] pin_out;
        logic [NUM_PINS-1:0] pin_oe;
        logic [7:0]          rdata;
        logic                reset_req;
    } top_state_t;

    top_state_t          q;
    top_state_t          d;
    logic [NUM_PINS-1:0] pin_lvl;
    logic [NUM_PINS-1:0] pin_chg;
    logic                rst_lvl;
    logic [NUM_PINS-1:0] general_input;
    logic                key_emit;
    logic                period_tick;
    int                  kidx;

    // Byte view of a pin group: 0 rows, 1 columns 0-7, 2 columns 8-9
    function automatic logic [7:0] get_grp(input logic [NUM_PINS-1:0] v, input int g);
        logic [7:0] r;
        r = 8'h00;
        if (g == 0)
            r = v[7:0];
        else if (g == 1)
            r = v[15:8];
        else
            r = {6'h00, v[17:16]};
        return r;
    endfunction

    function automatic logic [NUM_PINS-1:0] put_grp(input logic [NUM_PINS-1:0] v,
                                                    input int g, input logic [7:0] b);
        logic [NUM_PINS-1:0] r;
        r = v;
        if (g == 0)
            r[7:0] = b;
        else if (g == 1)
            r[15:8] = b;
        else
            r[17:16] = b[1:0];
        return r;
    endfunction

    // Lowest set bit of a pending vector
    function automatic logic [4:0] first_set(input logic [NUM_PINS-1:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = NUM_PINS - 1; i >= 0; i--)
        begin
            if (v[i])
                r = 5'(i);
        end
        return r;
    endfunction

    // Pin debounce with per-pin bypass
    stable_filter #(
        .W             (NUM_PINS),
        .STABLE_CYCLES (DEBOUNCE_LEN),
        .LEVEL_RST     ({NUM_PINS{1'b1}})
    ) u_pin_filter (
        .clk    (clk),
        .sys_rst(sys_rst),
        .raw    (pin_in),
        .bypass (q.dboff_snap),
        .level  (pin_lvl),
        .change (pin_chg)
    );

    // Reset pin filter, never bypassed
    stable_filter #(
        .W             (1),
        .STABLE_CYCLES (DEBOUNCE_LEN),
        .LEVEL_RST     (1'b1)
    ) u_rst_filter (
        .clk    (clk),
        .sys_rst(sys_rst),
        .raw    (rst_pin_n),
        .bypass (1'b0),
        .level  (rst_lvl),
        .change ()
    );

    always_comb
    begin
        d           = q;
        d.ev_valid  = 1'b0;
        key_emit    = 1'b0;
        period_tick = 1'b0;
        kidx        = int'(q.key_idx);
        general_input         = ~q.cfg.sel & ~q.cfg.dir;

        if (reg_wr)
        begin
            case (reg_addr)
                OFS_IRQ_EN_ROWS:    d.cfg.ien   = put_grp(q.cfg.ien, 0, reg_wdata);
                OFS_IRQ_EN_COLS_LO: d.cfg.ien   = put_grp(q.cfg.ien, 1, reg_wdata);
                OFS_IRQ_EN_COLS_HI: d.cfg.ien   = put_grp(q.cfg.ien, 2, reg_wdata);
                OFS_KP_SEL_ROWS:    d.cfg.sel   = put_grp(q.cfg.sel, 0, reg_wdata);
                OFS_KP_SEL_COLS_LO: d.cfg.sel   = put_grp(q.cfg.sel, 1, reg_wdata);
                OFS_KP_SEL_COLS_HI: d.cfg.sel   = put_grp(q.cfg.sel, 2, reg_wdata);
                OFS_EVT_EN_ROWS:    d.cfg.evt   = put_grp(q.cfg.evt, 0, reg_wdata);
                OFS_EVT_EN_COLS_LO: d.cfg.evt   = put_grp(q.cfg.evt, 1, reg_wdata);
                OFS_DIR_ROWS:
                begin
                    d.cfg.dir = put_grp(q.cfg.dir, 0, reg_wdata);
                    d.cfg.evt = put_grp(q.cfg.evt, 2, reg_wdata);
                end
                OFS_DIR_COLS_LO:    d.cfg.dir   = put_grp(q.cfg.dir, 1, reg_wdata);
                OFS_DIR_COLS_HI:    d.cfg.dir   = put_grp(q.cfg.dir, 2, reg_wdata);
                OFS_POL_ROWS:       d.cfg.pol   = put_grp(q.cfg.pol, 0, reg_wdata);
                OFS_POL_COLS_LO:    d.cfg.pol   = put_grp(q.cfg.pol, 1, reg_wdata);
                OFS_POL_COLS_HI:    d.cfg.pol   = put_grp(q.cfg.pol, 2, reg_wdata);
                OFS_DBOFF_ROWS:     d.cfg.dboff = put_grp(q.cfg.dboff, 0, reg_wdata);
                OFS_DBOFF_COLS_LO:  d.cfg.dboff = put_grp(q.cfg.dboff, 1, reg_wdata);
                OFS_DBOFF_COLS_HI:  d.cfg.dboff = put_grp(q.cfg.dboff, 2, reg_wdata);
                default:            d.cfg       = q.cfg;
            endcase
        end

        if (reg_rd)
        begin
            case (reg_addr)
                OFS_PIN_STATE_ROWS:    d.rdata = get_grp(q.pin_state, 0);
                OFS_PIN_STATE_COLS_LO: d.rdata = get_grp(q.pin_state, 1);
                OFS_PIN_STATE_COLS_HI: d.rdata = get_grp(q.pin_state, 2) & HI_GROUP_MSK;
                OFS_IRQ_EN_ROWS:       d.rdata = get_grp(q.cfg.ien, 0);
                OFS_IRQ_EN_COLS_LO:    d.rdata = get_grp(q.cfg.ien, 1);
                OFS_IRQ_EN_COLS_HI:    d.rdata = get_grp(q.cfg.ien, 2);
                OFS_KP_SEL_ROWS:       d.rdata = get_grp(q.cfg.sel, 0);
                OFS_KP_SEL_COLS_LO:    d.rdata = get_grp(q.cfg.sel, 1);
                OFS_KP_SEL_COLS_HI:    d.rdata = get_grp(q.cfg.sel, 2);
                OFS_EVT_EN_ROWS:       d.rdata = get_grp(q.cfg.evt, 0);
                OFS_EVT_EN_COLS_LO:    d.rdata = get_grp(q.cfg.evt, 1);
                OFS_DIR_ROWS:          d.rdata = get_grp(q.cfg.dir, 0);
                OFS_DIR_COLS_LO:       d.rdata = get_grp(q.cfg.dir, 1);
                OFS_DIR_COLS_HI:       d.rdata = get_grp(q.cfg.dir, 2);
                OFS_POL_ROWS:          d.rdata = get_grp(q.cfg.pol, 0);
                OFS_POL_COLS_LO:       d.rdata = get_grp(q.cfg.pol, 1);
                OFS_POL_COLS_HI:       d.rdata = get_grp(q.cfg.pol, 2);
                OFS_DBOFF_ROWS:        d.rdata = get_grp(q.cfg.dboff, 0);
                OFS_DBOFF_COLS_LO:     d.rdata = get_grp(q.cfg.dboff, 1);
                OFS_DBOFF_COLS_HI:     d.rdata = get_grp(q.cfg.dboff, 2);
                default:               d.rdata = 8'h00;
            endcase
        end

        d.dboff_snap = q.cfg.dboff;

        if (q.period_cnt == PW'(PERIOD_LEN - 1))
        begin
            d.period_cnt = '0;
            period_tick  = 1'b1;
        end
        else
        begin
            d.period_cnt = q.period_cnt + PW'(1);
        end

        unique case (q.state)
            ST_WAIT:
            begin
                if (period_tick)
                begin
                    d.sel_snap = q.cfg.sel;
                    d.col      = 4'h0;
                    d.slot_cnt = '0;
                    d.state    = ST_SLOT;
                end
            end
            ST_SLOT:
            begin
                if (q.slot_cnt == SW'(SLOT_LEN - 1))
                begin
                    d.slot_cnt = '0;
                    for (int r = 0; r < NUM_ROWS; r++)
                    begin
                        d.cur_img[r * NUM_COLS + int'(q.col)] = q.sel_snap[r]
                            & q.sel_snap[NUM_ROWS + int'(q.col)] & ~pin_lvl[r];
                    end
                    if (q.col == 4'(NUM_COLS - 1))
                    begin
                        d.key_idx = 7'h00;
                        d.state   = ST_EMIT;
                    end
                    else
                    begin
                        d.col = q.col + 4'h1;
                    end
                end
                else
                begin
                    d.slot_cnt = q.slot_cnt + SW'(1);
                end
            end
            ST_EMIT:
            begin
                if (q.cur_img[kidx] == q.prev_img[kidx] && q.cur_img[kidx] != q.rep_img[kidx])
                begin
                    key_emit         = 1'b1;
                    d.rep_img[kidx]  = q.cur_img[kidx];
                    d.ev_valid       = 1'b1;
                    d.ev.press       = q.cur_img[kidx];
                    d.ev.code        = 7'(kidx + KEY_CODE_BASE);
                end
                if (q.key_idx == 7'(NUM_KEYS - 1))
                begin
                    d.prev_img = q.cur_img;
                    d.state    = ST_WAIT;
                end
                else
                begin
                    d.key_idx = q.key_idx + 7'h01;
                end
            end
        endcase

        // General input events, new change wins over emission
        if (!key_emit && q.gpi_pend != PINS_RESET)
        begin
            d.ev_valid                  = 1'b1;
            d.gpi_pend[first_set(q.gpi_pend)] = 1'b0;
            d.ev.press = q.gpi_press[first_set(q.gpi_pend)];
            d.ev.code  = 7'(GPI_CODE_BASE + int'(first_set(q.gpi_pend)));
        end
        for (int i = 0; i < NUM_PINS; i++)
        begin
            if (pin_chg[i] && general_input[i])
            begin
                if (q.cfg.evt[i])
                begin
                    d.gpi_pend[i]  = 1'b1;
                    d.gpi_press[i] = ~pin_lvl[i];
                end
            end
        end

        if (irq_flag_clear)
            d.irq_flag = 1'b0;
        if ((q.cfg.ien & general_input & pin_chg & ~(pin_lvl ^ q.cfg.pol)) != PINS_RESET)
            d.irq_flag = 1'b1;

        for (int i = 0; i < NUM_PINS; i++)
        begin
            if (!q.cfg.sel[i] && q.cfg.dir[i])
                d.pin_state[i] = gpo_data[i];
            else if (q.dboff_snap[i] || pin_chg[i])
                d.pin_state[i] = pin_lvl[i];
        end

        for (int i = 0; i < NUM_PINS; i++)
        begin
            d.pin_oe[i]  = ~q.cfg.sel[i] & q.cfg.dir[i];
            d.pin_out[i] = gpo_data[i] & d.pin_oe[i];
        end
        if (q.state == ST_SLOT && q.sel_snap[NUM_ROWS + int'(q.col)])
        begin
            d.pin_oe[NUM_ROWS + int'(q.col)]  = 1'b1;
            d.pin_out[NUM_ROWS + int'(q.col)] = 1'b0;
        end

        d.reset_req = ~rst_lvl;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q            <= '0;
            q.cfg        <= '0;
            q.state      <= ST_WAIT;
            q.rdata      <= REG_RESET;
            q.pin_state  <= PINS_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign reg_rdata              = q.rdata;
    assign pin_out                = q.pin_out;
    assign pin_oe                 = q.pin_oe;
    assign reset_req              = q.reset_req;
    assign event_valid            = q.ev_valid;
    assign event_code             = {q.ev.press, q.ev.code};
    assign general_input_irq_flag = q.irq_flag;

endmodule // keypad_gpio_pin_config
`default_nettype wire

// [tb/keypad_matrix_model.sv]
// Behavioural key matrix and general purpose lines with pull-ups
`timescale 1ns/10ps
`default_nettype none
module keypad_matrix_model
    import keypad_gpio_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] pin_out,
    input  wire logic [NUM_PINS-1:0] pin_oe,
    input  wire logic [NUM_PINS-1:0] line_level,
    input  wire logic                key_down,
    input  wire logic [2:0]          key_row,
    input  wire logic [3:0]          key_col,
    output logic      [NUM_PINS-1:0] pin_in
);
    always_comb
    begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & line_level);
        if (key_down && pin_oe[8 + key_col] && !pin_out[8 + key_col])
        begin
            pin_in[key_row] = 1'b0;
        end
    end
endmodule // keypad_matrix_model
`default_nettype wire

// [tb/keypad_gpio_pin_config_properties.sv]
// Port-level assertions for the keypad pin configuration block
`timescale 1ns/10ps
`default_nettype none
module keypad_gpio_pin_config_properties
    import keypad_gpio_pkg::*;
#(
    parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
)
(
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_rdata,
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe,
    input wire logic [NUM_PINS-1:0] gpo_data,
    input wire logic                rst_pin_n,
    input wire logic                reset_req,
    input wire logic                event_valid,
    input wire logic [7:0]          event_code,
    input wire logic                general_input_irq_flag,
    input wire logic                irq_flag_clear
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h22 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_hi_bits_zero: assert property (reg_rd && reg_addr == OFS_KP_SEL_COLS_HI
        |=> reg_rdata[7:2] == 6'h00)
        else $error("unused select bits not zero");
    a_code_range: assert property (event_valid
        |-> event_code[6:0] inside {[7'd1:7'd80], [7'd97:7'd114]})
        else $error("event code out of range");
    a_code_hold: assert property (!event_valid |-> $stable(event_code))
        else $error("event code moved without event");
    a_req_rise: assert property ($rose(reset_req) |-> !$past(rst_pin_n, DEBOUNCE_LEN))
        else $error("reset request before debounce");
    a_req_fall: assert property ($fell(reset_req) |-> $past(rst_pin_n, DEBOUNCE_LEN))
        else $error("reset request dropped before debounce");
    a_irq_sticky: assert property (general_input_irq_flag && !irq_flag_clear
        |=> general_input_irq_flag)
        else $error("irq flag lost without clear");
    a_out_follows: assert property ((pin_oe[7:0] & (pin_out[7:0] ^ $past(gpo_data[7:0])))
        == 8'h00)
        else $error("driven row differs from output data");
endmodule // keypad_gpio_pin_config_properties

bind keypad_gpio_pin_config keypad_gpio_pin_config_properties #(
    .DEBOUNCE_LEN(DEBOUNCE_LEN)
) keypad_gpio_pin_config_properties_inst (.clk, .sys_rst, .reg_rd, .reg_addr, .reg_rdata,
    .pin_out, .pin_oe, .gpo_data, .rst_pin_n, .reset_req, .event_valid, .event_code,
    .general_input_irq_flag, .irq_flag_clear);
`default_nettype wire

// [tb/test_keypad_gpio_pin_config.sv]
// Self-checking bench for the keypad pin configuration block
`timescale 1ns/10ps
`default_nettype none
module test_keypad_gpio_pin_config
    import keypad_gpio_pkg::*;
;
    localparam int DBL = 8;
    localparam int PER = 2000;
    logic                clk;
    logic                sys_rst;
    logic                reg_wr;
    logic                reg_rd;
    logic [7:0]          reg_addr;
    logic [7:0]          reg_wdata;
    logic [7:0]          reg_rdata;
    logic [NUM_PINS-1:0] pin_in;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe;
    logic [NUM_PINS-1:0] gpo_data;
    logic [NUM_PINS-1:0] line_level;
    logic                rst_pin_n;
    logic                reset_req;
    logic                event_valid;
    logic [7:0]          event_code;
    logic                irq_flag;
    logic                irq_flag_clear;
    logic                key_down;
    int                  fails;
    int                  n_checks;

    keypad_gpio_pin_config #(.DEBOUNCE_LEN(DBL), .PERIOD_LEN(PER), .SLOT_LEN(20))
    keypad_gpio_pin_config_inst (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .pin_in, .pin_out, .pin_oe, .gpo_data, .rst_pin_n, .reset_req,
        .event_valid, .event_code, .general_input_irq_flag(irq_flag), .irq_flag_clear);

    keypad_matrix_model keypad_matrix_model_inst (.pin_out, .pin_oe, .line_level,
        .key_down, .key_row(3'h0), .key_col(4'h0), .pin_in);

    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s exp=%h got=%h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_rd = 1'b1;
        reg_addr = a;
        tick();
        reg_rd = 1'b0;
        tick();
        chk("rdata", exp, reg_rdata);
    endtask
    // Zero as expected code means no event may appear in the window
    task automatic wait_evt(input logic [7:0] exp, input int bound);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < bound && !seen; i++)
        begin
            tick();
            seen = (event_valid === 1'b1);
        end
        if (exp == 8'h00)
            chk("quiet", 8'h00, {7'h00, seen});
        else
        begin
            chk("event", exp, seen ? event_code : 8'hXX);
            if (!seen)
                tally_and_finish();
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk(what, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic t_regs();
        rd(8'h14, 8'h00);
        rd(8'h1D, 8'h00);
        rd(8'h29, 8'h00);
        rd(8'h22, 8'h00);
        chk_bit("oe", 1'b0, |pin_oe);
        wr(8'h1F, 8'hFF);
        rd(8'h1F, 8'h03);
        wr(8'h30, 8'hA5);
        rd(8'h30, 8'hA5);
        wr(8'h1F, 8'h00);
        wr(8'h30, 8'h00);
        gpo_data = 18'h00004;
        wr(8'h23, 8'h05);
        chk("oe", 8'h05, pin_oe[7:0]);
        chk("out", 8'h04, pin_out[7:0] & pin_oe[7:0]);
        wr(8'h23, 8'h00);
        $display("done: registers");
    endtask
    task automatic t_gpi();
        wr(8'h20, 8'h12);
        wr(8'h29, 8'h0A);
        wr(8'h1A, 8'h02);
        rd(8'h14, 8'h0E);
        line_level[1] = 1'b0;
        wait_evt(8'hE2, 10);
        tick();
        chk_bit("irq", 1'b1, irq_flag);
        irq_flag_clear = 1'b1;
        tick();
        irq_flag_clear = 1'b0;
        wr(8'h26, 8'h02);
        chk_bit("irq", 1'b0, irq_flag);
        line_level[1] = 1'b1;
        wait_evt(8'h62, 10);
        tick();
        chk_bit("irq", 1'b1, irq_flag);
        line_level[3] = 1'b0;
        wait_evt(8'h00, 30);
        $display("done: general inputs");
    endtask
    task automatic t_debounce();
        line_level[4] = 1'b0;
        repeat (4) tick();
        line_level[4] = 1'b1;
        wait_evt(8'h00, 30);
        line_level[4] = 1'b0;
        wait_evt(8'h00, DBL);
        wait_evt(8'hE5, 12);
        $display("done: debounce");
    endtask
    task automatic t_rstpin();
        rst_pin_n = 1'b0;
        repeat (4) tick();
        rst_pin_n = 1'b1;
        repeat (20) tick();
        chk_bit("reset_req", 1'b0, reset_req);
        rst_pin_n = 1'b0;
        repeat (DBL + 6) tick();
        chk_bit("reset_req", 1'b1, reset_req);
        rst_pin_n = 1'b1;
        repeat (DBL + 6) tick();
        chk_bit("reset_req", 1'b0, reset_req);
        $display("done: reset pin");
    endtask
    task automatic t_matrix();
        wr(8'h1D, 8'h01);
        wr(8'h1E, 8'h01);
        key_down = 1'b1;
        wait_evt(8'h00, PER / 2);
        wait_evt(8'h81, 3 * PER);
        key_down = 1'b0;
        wait_evt(8'h01, 3 * PER);
        $display("done: matrix");
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        fails = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        gpo_data = 18'h00000;
        line_level = 18'h3FFFF;
        rst_pin_n = 1'b1;
        irq_flag_clear = 1'b0;
        key_down = 1'b0;
        repeat (3) tick();
        sys_rst = 1'b0;
        t_regs();
        t_gpi();
        t_debounce();
        t_rstpin();
        t_matrix();
        tally_and_finish();
    end
endmodule // test_keypad_gpio_pin_config
`default_nettype wire
